// [hpoc_defines.vh]
// Constants shared by the port power and over-current control block.
// Assumes an 8-bit register port with 16-bit byte addresses and a 100 MHz core clock.
`ifndef HPOC_DEFINES_VH
`define HPOC_DEFINES_VH

// ----------------------------------------------------------------------------
// Bus widths and port count
// ----------------------------------------------------------------------------
`define HPOC_ADDR_W          16
`define HPOC_DATA_W          8
`define HPOC_NUM_PORTS       6

// ----------------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------------
`define HPOC_ADDR_LOCKOUT    16'h30e1
`define HPOC_ADDR_MIN_WIDTH  16'h30ea
`define HPOC_ADDR_INACTIVE   16'h30eb
`define HPOC_ADDR_POWER_REQ  16'h3100
`define HPOC_ADDR_OC_STATUS  16'h3101
`define HPOC_ADDR_MODE_CFG   16'h3102
`define HPOC_ADDR_BC_ENABLE  16'h3103
`define HPOC_ADDR_PWR_STATE  16'h3104

// ----------------------------------------------------------------------------
// Field layouts and reset values
// ----------------------------------------------------------------------------
`define HPOC_MIN_WIDTH_W     4
`define HPOC_TIMER_W         8
`define HPOC_GANG_BIT        0
`define HPOC_RST_LOCKOUT     8'h0a
`define HPOC_RST_MIN_WIDTH   4'h5
`define HPOC_RST_INACTIVE    8'h14
`define HPOC_RST_PORTS       6'h00
`define HPOC_RST_GANG        1'b0
`define HPOC_RD_IDLE         8'h00

// ----------------------------------------------------------------------------
// Timing: one millisecond step of every filter timer
// ----------------------------------------------------------------------------
`define HPOC_CLK_PERIOD_NS   10
`define HPOC_STEP_NS         1000000
`define HPOC_STEP_CYCLES     (`HPOC_STEP_NS / `HPOC_CLK_PERIOD_NS)
`define HPOC_STEP_CNT_W      17

`endif

// [hpoc_ocs_filter.v]
// Over-current sense filter for one control pin: lockout, single and double pulse.
// Assumes a one-cycle millisecond tick and a sense input synchronous to the clock.
`timescale 1ns/1ps
`default_nettype none
`include "hpoc_defines.vh"

module hpoc_ocs_filter #(
  parameter MW = `HPOC_MIN_WIDTH_W,
  parameter TW = `HPOC_TIMER_W
) (
  input  wire          clock,
  input  wire          rst_n,
  input  wire          msTick,
  input  wire          powerOn,
  input  wire          senseLow,
  input  wire [MW-1:0] minWidth,
  input  wire [TW-1:0] inactiveMs,
  input  wire [TW-1:0] lockoutMs,
  output wire          ocEvent,
  output wire          lockActive
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  reg          powerOnDly_q;
  reg [TW-1:0] lockCnt_q;
  reg [MW-1:0] lowCnt_q;
  reg          lowDly_q;
  reg [TW-1:0] winCnt_q;
  reg          ocEvent_q;

  assign ocEvent    = ocEvent_q;
  assign lockActive = (lockCnt_q != {TW{1'b0}});

  // Power-on edge loads the lockout, then low samples are timed in ms steps.
  // A lone low group opens the rolling window; a new group inside it trips.
  always @(posedge clock) begin
    if (!rst_n) begin
      powerOnDly_q <= 1'b0;
      lockCnt_q    <= {TW{1'b0}};
      lowCnt_q     <= {MW{1'b0}};
      lowDly_q     <= 1'b0;
      winCnt_q     <= {TW{1'b0}};
      ocEvent_q    <= 1'b0;
    end else begin
      powerOnDly_q <= powerOn;
      ocEvent_q    <= 1'b0;
      if (!powerOn) begin
        lockCnt_q <= {TW{1'b0}};
        lowCnt_q  <= {MW{1'b0}};
        lowDly_q  <= 1'b0;
        winCnt_q  <= {TW{1'b0}};
      end else if (!powerOnDly_q) begin
        lockCnt_q <= lockoutMs;
        lowCnt_q  <= {MW{1'b0}};
        lowDly_q  <= 1'b0;
        winCnt_q  <= {TW{1'b0}};
      end else if (lockActive) begin
        // The pin is ignored while slow supply ramps settle.
        lowDly_q <= 1'b0;
        if (msTick) begin
          lockCnt_q <= lockCnt_q - 1'b1;
        end
      end else begin
        lowDly_q <= senseLow;
        if (senseLow) begin
          if (lowCnt_q >= minWidth) begin
            ocEvent_q <= 1'b1;
            lowCnt_q  <= {MW{1'b0}};
            winCnt_q  <= {TW{1'b0}};
          end else if (!lowDly_q && (winCnt_q != {TW{1'b0}})) begin
            ocEvent_q <= 1'b1;
            lowCnt_q  <= {MW{1'b0}};
            winCnt_q  <= {TW{1'b0}};
          end else if (msTick) begin
            lowCnt_q <= lowCnt_q + 1'b1;
          end
        end else begin
          lowCnt_q <= {MW{1'b0}};
          if (lowDly_q) begin
            winCnt_q <= inactiveMs;
          end else if (msTick && (winCnt_q != {TW{1'b0}})) begin
            winCnt_q <= winCnt_q - 1'b1;
          end
        end
      end
    end
  end

endmodule
`default_nettype wire

// [hpoc_port_ctrl.v]
// Downstream port power control and over-current sensing for a six-port hub.
// Assumes an 8-bit register port, a configuration-load strobe window from the
// serial management or one-time-memory loader, and an external switch or fuse.
//
// Operation
// - One pin per port for power and sense.
// - Ganged mode uses one shared pin for all.
// - Individual mode gives each port its pin.
// - Gang select only by configuration load.
// - Individual mode after reset by default.
// - Ganged over-current flags every port.
// - Power off drives the pin low.
// - Pull-up disabled while driving low.
// - Power on releases driver, enables pull-up.
// - Low on enabled pin means over-current.
// - Filter transient lows on the sense input.
// - Battery charging selectable per port.
// - Charger presence signalled per port pin.
// - Sample the pin continuously while enabled.
// - Long low pulse trips, 1 ms steps.
// - Two low groups in window trip.
// - Ignore pin for lockout after power on.
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "hpoc_defines.vh"

module hpoc_port_ctrl #(
  parameter NP         = `HPOC_NUM_PORTS,
  parameter STEP_CYCLES = `HPOC_STEP_CYCLES
) (
  input  wire                      clock,
  input  wire                      rst_n,
  input  wire [`HPOC_ADDR_W-1:0]   regAddr,
  input  wire [`HPOC_DATA_W-1:0]   regWrData,
  input  wire                      regWrEn,
  input  wire                      regRdEn,
  output wire [`HPOC_DATA_W-1:0]   regRdData,
  input  wire                      cfgLoadEn,
  input  wire [NP-1:0]             portCtlPinIn,
  output wire [NP-1:0]             portCtlPinOut,
  output wire [NP-1:0]             portCtlPinOe,
  output wire [NP-1:0]             portCtlPullUpEn,
  input  wire                      sharedPowerPinIn,
  output wire                      sharedPowerPinOut,
  output wire                      sharedPowerPinOe,
  output wire                      sharedPowerPullUpEn,
  output wire [NP-1:0]             ocFlags,
  output wire                      gangedMode
);

  // --------------------------------------------------------------------------
  // Millisecond step generator
  // --------------------------------------------------------------------------
  // One tick serves every filter, so all timers share the same step phase.
  // The first step after power-on can therefore be shorter than a full ms.
  // The step count is cut to the counter width on purpose; the count must fit.
  localparam integer                STEP_LAST_I = STEP_CYCLES - 1;
  localparam [`HPOC_STEP_CNT_W-1:0] STEP_LAST   = STEP_LAST_I[`HPOC_STEP_CNT_W-1:0];

  reg [`HPOC_STEP_CNT_W-1:0] stepCnt_q;
  reg                        msTick_q;

  always @(posedge clock) begin
    if (!rst_n) begin
      stepCnt_q <= {`HPOC_STEP_CNT_W{1'b0}};
      msTick_q  <= 1'b0;
    end else if (stepCnt_q == STEP_LAST) begin
      stepCnt_q <= {`HPOC_STEP_CNT_W{1'b0}};
      msTick_q  <= 1'b1;
    end else begin
      stepCnt_q <= stepCnt_q + 1'b1;
      msTick_q  <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------------
  reg [`HPOC_TIMER_W-1:0]     lockoutMs_q;
  reg [`HPOC_MIN_WIDTH_W-1:0] minWidth_q;
  reg [`HPOC_TIMER_W-1:0]     inactiveMs_q;
  reg [NP-1:0]                powerReq_q;
  reg [NP-1:0]                bcEnable_q;
  reg                         gang_q;
  reg [NP-1:0]                ocFlag_q;
  reg [NP-1:0]                ocFlag_d;
  reg [`HPOC_DATA_W-1:0]      rdData_q;
  reg [`HPOC_DATA_W-1:0]      rdData_d;

  // Decoded write strobes, one per register except the read-only power state.
  wire wrLockout  = regWrEn && (regAddr == `HPOC_ADDR_LOCKOUT);
  wire wrMinWidth = regWrEn && (regAddr == `HPOC_ADDR_MIN_WIDTH);
  wire wrInactive = regWrEn && (regAddr == `HPOC_ADDR_INACTIVE);
  wire wrPowerReq = regWrEn && (regAddr == `HPOC_ADDR_POWER_REQ);
  wire wrOcStatus = regWrEn && (regAddr == `HPOC_ADDR_OC_STATUS);
  wire wrModeCfg  = regWrEn && (regAddr == `HPOC_ADDR_MODE_CFG);
  wire wrBcEnable = regWrEn && (regAddr == `HPOC_ADDR_BC_ENABLE);

  // Writable registers. The mode bit only moves inside the configuration
  // load window, so runtime software cannot flip the pin topology under load.
  always @(posedge clock) begin
    if (!rst_n) begin
      lockoutMs_q  <= `HPOC_RST_LOCKOUT;
      minWidth_q   <= `HPOC_RST_MIN_WIDTH;
      inactiveMs_q <= `HPOC_RST_INACTIVE;
      powerReq_q   <= `HPOC_RST_PORTS;
      bcEnable_q   <= `HPOC_RST_PORTS;
      gang_q       <= `HPOC_RST_GANG;
    end else begin
      if (wrLockout) begin
        lockoutMs_q <= regWrData;
      end
      if (wrMinWidth) begin
        minWidth_q <= regWrData[`HPOC_MIN_WIDTH_W-1:0];
      end
      if (wrInactive) begin
        inactiveMs_q <= regWrData;
      end
      if (wrPowerReq) begin
        powerReq_q <= regWrData[NP-1:0];
      end
      if (wrBcEnable) begin
        bcEnable_q <= regWrData[NP-1:0];
      end
      if (wrModeCfg && cfgLoadEn) begin
        gang_q <= regWrData[`HPOC_GANG_BIT];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Power decision
  // --------------------------------------------------------------------------
  // A charging port keeps its supply switched on so the external charger
  // stays presented on that pin even when the host has not asked for power.
  wire [NP-1:0] portWant  = powerReq_q | bcEnable_q;
  wire          anyWant   = |portWant;
  wire [NP-1:0] indivOn   = gang_q ? {NP{1'b0}} : portWant;
  wire          sharedOn  = gang_q && anyWant;

  // Registered pin controls. The output value is always low; only the
  // enable moves, which gives the open-drain behaviour on the wire.
  reg [NP-1:0] pinOe_q;
  reg [NP-1:0] pinPull_q;
  reg [NP-1:0] portOn_q;
  reg          shOe_q;
  reg          shPull_q;
  reg          shOn_q;

  always @(posedge clock) begin
    if (!rst_n) begin
      pinOe_q   <= {NP{1'b1}};
      pinPull_q <= {NP{1'b0}};
      portOn_q  <= {NP{1'b0}};
      shOe_q    <= 1'b0;
      shPull_q  <= 1'b0;
      shOn_q    <= 1'b0;
    end else begin
      // Unused port pins are parked, neither driven nor pulled, in ganged mode.
      pinOe_q   <= gang_q ? {NP{1'b0}} : ~indivOn;
      pinPull_q <= indivOn;
      portOn_q  <= indivOn;
      shOe_q    <= gang_q && !sharedOn;
      shPull_q  <= sharedOn;
      shOn_q    <= sharedOn;
    end
  end

  assign portCtlPinOut       = {NP{1'b0}};
  assign portCtlPinOe        = pinOe_q;
  assign portCtlPullUpEn     = pinPull_q;
  assign sharedPowerPinOut   = 1'b0;
  assign sharedPowerPinOe    = shOe_q;
  assign sharedPowerPullUpEn = shPull_q;
  assign gangedMode          = gang_q;

  // --------------------------------------------------------------------------
  // Over-current filters
  // --------------------------------------------------------------------------
  // A low pin while released can only come from the switch or fuse pulling
  // it down, since our own driver is off at that time.
  // The lockout state of each filter is not mapped, so it is left open.
  wire [NP-1:0] portEvt;
  wire          sharedEvt;

  genvar gi;
  generate
    for (gi = 0; gi < NP; gi = gi + 1) begin : gPort
      hpoc_ocs_filter #(
        .MW (`HPOC_MIN_WIDTH_W),
        .TW (`HPOC_TIMER_W)
      ) uFilt (
        .clock      (clock),
        .rst_n      (rst_n),
        .msTick     (msTick_q),
        .powerOn    (portOn_q[gi]),
        .senseLow   (~portCtlPinIn[gi]),
        .minWidth   (minWidth_q),
        .inactiveMs (inactiveMs_q),
        .lockoutMs  (lockoutMs_q),
        .ocEvent    (portEvt[gi]),
        .lockActive ()
      );
    end
  endgenerate

  hpoc_ocs_filter #(
    .MW (`HPOC_MIN_WIDTH_W),
    .TW (`HPOC_TIMER_W)
  ) uSharedFilt (
    .clock      (clock),
    .rst_n      (rst_n),
    .msTick     (msTick_q),
    .powerOn    (shOn_q),
    .senseLow   (~sharedPowerPinIn),
    .minWidth   (minWidth_q),
    .inactiveMs (inactiveMs_q),
    .lockoutMs  (lockoutMs_q),
    .ocEvent    (sharedEvt),
    .lockActive ()
  );

  // --------------------------------------------------------------------------
  // Over-current status
  // --------------------------------------------------------------------------
  // Sticky flags, cleared by writing ones. A detection in the same cycle as
  // the clear wins, so no event is lost to a racing software clear.
  wire [NP-1:0] ocSet = gang_q ? {NP{sharedEvt}} : portEvt;
  wire [NP-1:0] ocClr = wrOcStatus ? regWrData[NP-1:0] : {NP{1'b0}};

  always @* begin
    ocFlag_d = (ocFlag_q & ~ocClr) | ocSet;
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      ocFlag_q <= `HPOC_RST_PORTS;
    end else begin
      ocFlag_q <= ocFlag_d;
    end
  end

  assign ocFlags = ocFlag_q;

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  // Reserved and unmapped bits read as zero. Data is registered and valid in
  // the cycle after the read strobe only; it returns to zero afterwards.
  wire [`HPOC_DATA_W-1:0] pwrState = {1'b0, shOn_q, portOn_q};

  always @* begin
    rdData_d = `HPOC_RD_IDLE;
    if (regRdEn) begin
      if (regAddr == `HPOC_ADDR_LOCKOUT) begin
        rdData_d = lockoutMs_q;
      end else if (regAddr == `HPOC_ADDR_MIN_WIDTH) begin
        rdData_d = {{(`HPOC_DATA_W-`HPOC_MIN_WIDTH_W){1'b0}}, minWidth_q};
      end else if (regAddr == `HPOC_ADDR_INACTIVE) begin
        rdData_d = inactiveMs_q;
      end else if (regAddr == `HPOC_ADDR_POWER_REQ) begin
        rdData_d = {{(`HPOC_DATA_W-NP){1'b0}}, powerReq_q};
      end else if (regAddr == `HPOC_ADDR_OC_STATUS) begin
        rdData_d = {{(`HPOC_DATA_W-NP){1'b0}}, ocFlag_q};
      end else if (regAddr == `HPOC_ADDR_MODE_CFG) begin
        rdData_d = {{(`HPOC_DATA_W-1){1'b0}}, gang_q};
      end else if (regAddr == `HPOC_ADDR_BC_ENABLE) begin
        rdData_d = {{(`HPOC_DATA_W-NP){1'b0}}, bcEnable_q};
      end else if (regAddr == `HPOC_ADDR_PWR_STATE) begin
        rdData_d = pwrState;
      end else begin
        rdData_d = `HPOC_RD_IDLE;
      end
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      rdData_q <= `HPOC_RD_IDLE;
    end else begin
      rdData_q <= rdData_d;
    end
  end

  assign regRdData = rdData_q;

endmodule
`default_nettype wire

// [hpoc_port_ctrl_properties.sv]
// Checker for the port power and over-current block, bound to its top module.
// Assumes the shared defines header and one clock with a synchronous reset.
`timescale 1ns/1ps
`default_nettype none
`include "hpoc_defines.vh"

module hpoc_port_ctrl_checker #(
  parameter NP = 6
) (
  input wire                    clock,
  input wire                    rst_n,
  input wire [`HPOC_ADDR_W-1:0] regAddr,
  input wire [`HPOC_DATA_W-1:0] regWrData,
  input wire                    regWrEn,
  input wire                    cfgLoadEn,
  input wire [NP-1:0]           portCtlPinOut,
  input wire [NP-1:0]           portCtlPinOe,
  input wire [NP-1:0]           portCtlPullUpEn,
  input wire                    sharedPowerPinOut,
  input wire                    sharedPowerPinOe,
  input wire                    sharedPowerPullUpEn,
  input wire [NP-1:0]           ocFlags,
  input wire                    gangedMode
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // ---------------------------------------------------------------------------
  // Sequences
  // ---------------------------------------------------------------------------
  // Software asks for power on port 0 while the pins follow their own ports.
  sequence s_power_on0;
    regWrEn && regAddr == `HPOC_ADDR_POWER_REQ && regWrData[0] && !gangedMode && !cfgLoadEn;
  endsequence
  // Some over-current flag has just come up.
  sequence s_new_flag;
    (ocFlags & ~$past(ocFlags)) != 0;
  endsequence

  // ---------------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------------
  // The pin registers trail the mode bit, so mode checks wait two cycles.
  a_drive_is_low: assert property ((portCtlPinOut == 0) && !sharedPowerPinOut)
    else $error("pin drive value is not low");
  a_pull_off_driving: assert property ((portCtlPinOe & portCtlPullUpEn) == 0)
    else $error("pull-up on while pin driven");
  a_gang_parks_ports: assert property (gangedMode && $past(gangedMode, 2)
    |-> portCtlPinOe == 0 && portCtlPullUpEn == 0)
    else $error("port pins active in ganged mode");
  a_indiv_shared_idle: assert property (!gangedMode && !$past(gangedMode, 2)
    |-> !sharedPowerPinOe && !sharedPowerPullUpEn)
    else $error("shared pin active in individual mode");
  a_shared_one_state: assert property (gangedMode && $past(gangedMode, 2)
    |-> sharedPowerPinOe != sharedPowerPullUpEn)
    else $error("shared pin neither driven nor released");
  a_mode_by_cfg: assert property ($changed(gangedMode) |-> $past(cfgLoadEn))
    else $error("mode changed outside configuration load");
  a_flag_w1c_only: assert property ((|($past(ocFlags) & ~ocFlags))
    |-> $past(regWrEn && regAddr == `HPOC_ADDR_OC_STATUS))
    else $error("over-current flag cleared without write");
  a_gang_flags_all: assert property (gangedMode ##0 s_new_flag |-> &ocFlags)
    else $error("ganged over-current did not flag every port");
  a_power_on_release: assert property (s_power_on0
    |-> ##2 portCtlPullUpEn[0] && !portCtlPinOe[0])
    else $error("port pin not released after power request");
  a_lockout_quiet: assert property ($rose(portCtlPullUpEn[0]) && !gangedMode
    |-> ##1 (!$rose(ocFlags[0])) [*3])
    else $error("over-current flagged inside lockout");
endmodule

bind hpoc_port_ctrl hpoc_port_ctrl_checker #(.NP(NP)) chk (
  .clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
  .regWrEn(regWrEn), .cfgLoadEn(cfgLoadEn), .portCtlPinOut(portCtlPinOut),
  .portCtlPinOe(portCtlPinOe), .portCtlPullUpEn(portCtlPullUpEn),
  .sharedPowerPinOut(sharedPowerPinOut), .sharedPowerPinOe(sharedPowerPinOe),
  .sharedPowerPullUpEn(sharedPowerPullUpEn), .ocFlags(ocFlags), .gangedMode(gangedMode));
`default_nettype wire

// [hpoc_pwr_switch_model.sv]
// Behavioural external power switch, one channel per control pin.
// Assumes the block drives a pin only through its output enable.
`timescale 1ns/1ps
`default_nettype none

module hpoc_pwr_switch_model #(
  parameter int N = 6
) (
  input  wire logic         clock,
  input  wire logic [N-1:0] pinOe,
  input  wire logic [N-1:0] pinOut,
  input  wire logic [N-1:0] pullUpEn,
  input  wire logic [N-1:0] faultLow,
  output logic [N-1:0]      pinLevel
);
  logic floatQ = 1'b0;

  // An undriven pin without pull-up wanders; toggling stops a lucky settle.
  always @(posedge clock) begin
    floatQ <= ~floatQ;
  end

  // Block drive wins; otherwise the open-drain fault output pulls low.
  always_comb begin
    pinLevel = (pinOe & pinOut) | (~pinOe & ~faultLow & (pullUpEn | {N{floatQ}}));
  end
endmodule
`default_nettype wire

// [hpoc_port_ctrl_tb.sv]
// Self-checking bench for the port power and over-current block.
// Assumes the shared defines header and the switch model beside it.
`timescale 1ns/1ps
`default_nettype none
`include "hpoc_defines.vh"

module hpoc_port_ctrl_tb;
  logic        clock       = 1'b0;
  logic        rst_n       = 1'b0;
  logic [15:0] regAddr     = 16'h0000;
  logic [7:0]  regWrData   = 8'h00;
  logic        regWrEn     = 1'b0;
  logic        regRdEn     = 1'b0;
  logic        cfgLoadEn   = 1'b0;
  logic [5:0]  portFault   = 6'h00;
  logic        sharedFault = 1'b0;
  wire  [7:0]  regRdData;
  wire  [5:0]  portPin, portOut, portOe, portPull, ocFlags;
  wire         sharedPin, sharedOut, sharedOe, sharedPull, gangedMode;
  int          error_cnt   = 0;
  int          num_checks  = 0;

  // A 20-cycle millisecond keeps every timer short.
  hpoc_port_ctrl #(.NP(6), .STEP_CYCLES(20)) uut (
    .clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .cfgLoadEn(cfgLoadEn),
    .portCtlPinIn(portPin), .portCtlPinOut(portOut), .portCtlPinOe(portOe),
    .portCtlPullUpEn(portPull), .sharedPowerPinIn(sharedPin), .sharedPowerPinOut(sharedOut),
    .sharedPowerPinOe(sharedOe), .sharedPowerPullUpEn(sharedPull), .ocFlags(ocFlags),
    .gangedMode(gangedMode));
  hpoc_pwr_switch_model #(.N(6)) portSw (.clock(clock), .pinOe(portOe), .pinOut(portOut),
    .pullUpEn(portPull), .faultLow(portFault), .pinLevel(portPin));
  hpoc_pwr_switch_model #(.N(1)) shareSw (.clock(clock), .pinOe(sharedOe), .pinOut(sharedOut),
    .pullUpEn(sharedPull), .faultLow(sharedFault), .pinLevel(sharedPin));

  // Clock of 100 MHz.
  always #5 clock = ~clock;

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic print_verdict;
    if (error_cnt == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h got %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr   <= a;
    regWrData <= d;
    regWrEn   <= 1'b1;
    @(posedge clock);
    regWrEn   <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so look there.
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clock);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clock);
    regRdEn <= 1'b0;
    #1 chk($sformatf("reg %h", a), exp, regRdData);
  endtask

  // Pin registers settle one cycle after the request register is taken.
  task automatic pins(input logic [5:0] oe, input logic [5:0] pull, input logic sOe,
                      input logic sPull);
    cyc(2);
    #1 chk("port oe", {2'b00, oe}, {2'b00, portOe});
    chk("port pull", {2'b00, pull}, {2'b00, portPull});
    chk("shared oe", {7'h00, sOe}, {7'h00, sharedOe});
    chk("shared pull", {7'h00, sPull}, {7'h00, sharedPull});
    chk("port out", 8'h00, {2'b00, portOut});
    chk("shared out", 8'h00, {7'h00, sharedOut});
  endtask

  // Bit 6 faults the shared pin, bits 5:0 the port pins.
  task automatic fault(input logic [6:0] f, input int n);
    @(posedge clock);
    {sharedFault, portFault} <= f;
    cyc(n);
    {sharedFault, portFault} <= 7'h00;
  endtask

  task automatic waitFlag(input logic [5:0] m);
    int i;
    for (i = 0; i < 400 && (ocFlags & m) !== m; i++) @(posedge clock);
    if (i == 400) begin
      error_cnt++;
      $display("ERROR oc flags expected %h got %h", m, ocFlags);
      print_verdict();
    end
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    cyc(8);
    rst_n <= 1'b1;
    rd(`HPOC_ADDR_LOCKOUT, 8'h0a);
    rd(`HPOC_ADDR_MIN_WIDTH, 8'h05);
    rd(`HPOC_ADDR_INACTIVE, 8'h14);
    rd(`HPOC_ADDR_MODE_CFG, 8'h00);
    rd(16'h3105, 8'h00);
    pins(6'h3f, 6'h00, 1'b0, 1'b0);
    wr(`HPOC_ADDR_MODE_CFG, 8'h01);
    rd(`HPOC_ADDR_MODE_CFG, 8'h00);
    wr(`HPOC_ADDR_MIN_WIDTH, 8'hf2);
    rd(`HPOC_ADDR_MIN_WIDTH, 8'h02);
    wr(`HPOC_ADDR_INACTIVE, 8'h03);
    wr(`HPOC_ADDR_LOCKOUT, 8'h04);
    wr(`HPOC_ADDR_POWER_REQ, 8'h3f);
    pins(6'h00, 6'h3f, 1'b0, 1'b0);
    rd(`HPOC_ADDR_PWR_STATE, 8'h3f);
    cyc(100);
    // A long low trips; a short one alone does not, a second within the window does.
    fault(7'h04, 80);
    waitFlag(6'h04);
    fault(7'h08, 5);
    cyc(10);
    chk("oc flags", 8'h04, {2'b00, ocFlags});
    fault(7'h08, 5);
    waitFlag(6'h0c);
    wr(`HPOC_ADDR_OC_STATUS, 8'h04);
    rd(`HPOC_ADDR_OC_STATUS, 8'h08);
    // Port 1 off, then on with its pin held low only inside the lockout.
    wr(`HPOC_ADDR_POWER_REQ, 8'h3d);
    pins(6'h02, 6'h3d, 1'b0, 1'b0);
    wr(`HPOC_ADDR_POWER_REQ, 8'h3f);
    fault(7'h02, 50);
    cyc(100);
    rd(`HPOC_ADDR_OC_STATUS, 8'h08);
    // A charging port stays released without a power request.
    wr(`HPOC_ADDR_POWER_REQ, 8'h3d);
    wr(`HPOC_ADDR_BC_ENABLE, 8'h02);
    pins(6'h00, 6'h3f, 1'b0, 1'b0);
    rd(`HPOC_ADDR_BC_ENABLE, 8'h02);
    wr(`HPOC_ADDR_OC_STATUS, 8'h3f);
    wr(`HPOC_ADDR_BC_ENABLE, 8'h00);
    // Ganged mode through the configuration load window.
    @(posedge clock) cfgLoadEn <= 1'b1;
    wr(`HPOC_ADDR_MODE_CFG, 8'h01);
    cfgLoadEn <= 1'b0;
    rd(`HPOC_ADDR_MODE_CFG, 8'h01);
    chk("ganged mode", 8'h01, {7'h00, gangedMode});
    pins(6'h00, 6'h00, 1'b0, 1'b1);
    wr(`HPOC_ADDR_POWER_REQ, 8'h00);
    pins(6'h00, 6'h00, 1'b1, 1'b0);
    wr(`HPOC_ADDR_POWER_REQ, 8'h20);
    pins(6'h00, 6'h00, 1'b0, 1'b1);
    cyc(100);
    fault(7'h40, 80);
    waitFlag(6'h3f);
    wr(`HPOC_ADDR_OC_STATUS, 8'h3f);
    rd(`HPOC_ADDR_OC_STATUS, 8'h00);
    // A second reset returns to individual mode with ports unpowered.
    @(posedge clock) rst_n <= 1'b0;
    cyc(8);
    rst_n <= 1'b1;
    rd(`HPOC_ADDR_MODE_CFG, 8'h00);
    chk("port oe", 8'h3f, {2'b00, portOe});
    chk("ganged mode", 8'h00, {7'h00, gangedMode});
    print_verdict();
  end
endmodule
`default_nettype wire
